// File: rtl/ctr_pkg.sv
// Constants and types for the clock trim and reset control block
//
// Behaviour
// - Internal RC mode supplies a nominal 4 MHz system clock without external parts.
// - Factory trim sits in last program word as a return-with-literal instruction.
// - Fine trim bits 7..4 raise oscillator frequency monotonically with value.
// - Bit 3 gives a large step up, bit 2 a large step down.
// - Trim bits 1 and 0 are unimplemented; software writes them as zero.
// - Divided clock drives the second oscillator pin only in modes 101 and 111.
// - Divided clock runs at oscillator frequency divided by four.
// - Reset logic tells apart power-on, pin running, pin in sleep, watchdog resets.
// - Some registers are never reset; kept through every reset except power-on.
// - Other registers load reset values on power-on, pin and watchdog resets.
// - Watchdog wake-up from sleep keeps registers; the program counter is loaded with 000.
// - Timeout and powerdown flags follow the cause and stay readable.
// - Master clear pin path filters out short low pulses.
// - Watchdog reset acts internally and never drives the master clear pin.
// - Oscillator select decodes into eight modes, 011 being invalid.
// - Flags: power-on 1,1; watchdog reset 0,1; watchdog wake 0,0; pin sleep 1,0.
// - Interrupt wake with global enable loads vector 0004h, else next instruction.
package ctr_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTR_ADDR_TRIM = 12'h000;
  localparam logic [11:0] CTR_ADDR_CTRL = 12'h004;
  localparam logic [11:0] CTR_ADDR_STATUS = 12'h008;
  localparam logic [11:0] CTR_ADDR_VECTOR = 12'h00C;

  // Trim register layout and reset value
  localparam int CTR_FINE_LSB = 4;
  localparam int CTR_COARSE_UP_BIT = 3;
  localparam int CTR_COARSE_DN_BIT = 2;
  localparam logic [7:0] CTR_TRIM_MASK = 8'hFC;
  localparam logic [7:0] CTR_TRIM_RST = 8'h70;

  // Control register bits
  localparam int CTR_CTRL_SLEEP_BIT = 0;
  localparam int CTR_CTRL_GIE_BIT = 1;
  localparam int CTR_CTRL_SEL_LSB = 4;

  // Status register bits
  localparam int CTR_ST_TO_BIT = 0;
  localparam int CTR_ST_PD_BIT = 1;
  localparam int CTR_ST_CAUSE_LSB = 4;

  // Program counter targets
  localparam logic [10:0] CTR_INT_VECTOR = 11'h004;
  localparam logic [10:0] CTR_RESET_VECTOR = 11'h000;

  // Master clear filter and nominal clock
  localparam int CTR_MASTER_CLEAR_PIN_FILT_CYC = 8;
  localparam int CTR_INTERNAL_RC_MODE_KHZ = 4000;
  localparam int CTR_DIVIDED_CLOCK_OUT_DIV = 4;
  localparam logic [7:0] CTR_PSLVERR_NONE = 8'h00;

  // Oscillator select encodings
  typedef enum logic [2:0] {
    CTR_OSC_LP = 3'b000,
    CTR_OSC_XT = 3'b001,
    CTR_OSC_HS = 3'b010,
    CTR_OSC_BAD = 3'b011,
    CTR_OSC_IRC_IO = 3'b100,
    CTR_OSC_IRC_CLK = 3'b101,
    CTR_OSC_ERC_IO = 3'b110,
    CTR_OSC_ERC_CLK = 3'b111
  } ctr_osc_t;

  // Reset or wake cause codes
  typedef enum logic [2:0] {
    CTR_CAUSE_POR = 3'b000,
    CTR_CAUSE_MASTER_CLEAR_PIN_RUN = 3'b001,
    CTR_CAUSE_MASTER_CLEAR_PIN_SLP = 3'b010,
    CTR_CAUSE_WDT_RUN = 3'b011,
    CTR_CAUSE_WDT_WAKE = 3'b100,
    CTR_CAUSE_INT_WAKE = 3'b101
  } ctr_cause_t;

endpackage : ctr_pkg

// File: rtl/ctr_master_clear_pin_filter.sv
// Glitch filter for the master clear pin
`timescale 1ns/1ps
`default_nettype none
module ctr_master_clear_pin_filter #(
  parameter int FILT_CYC = ctr_pkg::CTR_MASTER_CLEAR_PIN_FILT_CYC
) (
  input wire logic pclk,       // Register clock
  input wire logic presetn,    // Async reset, low active
  input wire logic ce,         // Clock enable
  input wire logic pin_n,      // Raw master clear pin, low active
  output logic clear_req       // Filtered reset request level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic [7:0] cnt;
    logic req;
  } ctr_filt_t;

  ctr_filt_t st_r;
  ctr_filt_t st_nxt;

  // ---------------------------------------------------------------
  // Filter logic
  // ---------------------------------------------------------------
  // Two-stage sync, then count a sustained low level
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = pin_n;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2)
    begin
      st_nxt.cnt = 8'h00;
      st_nxt.req = 1'b0;
    end
    else if (st_r.cnt == 8'(FILT_CYC - 1))
      st_nxt.req = 1'b1;
    else
      st_nxt.cnt = st_r.cnt + 8'h01;
  end

  // Pin idles high so sync stages reset to one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, req: 1'b0};
    else if (ce)
      st_r <= st_nxt;
  end

  assign clear_req = st_r.req;

endmodule : ctr_master_clear_pin_filter
`default_nettype wire

// File: rtl/ctr_divided_clock_out_div.sv
// Divide-by-four clock output generator
`timescale 1ns/1ps
`default_nettype none
module ctr_divided_clock_out_div (
  input wire logic pclk,       // Oscillator clock
  input wire logic presetn,    // Async reset, low active
  input wire logic ce,         // Clock enable
  input wire logic hold,       // Holds divider with output low
  output logic div_clk         // Oscillator over four
);

  typedef struct packed {
    logic [1:0] ph;
    logic q;
  } ctr_div_t;

  ctr_div_t st_r;
  ctr_div_t st_nxt;

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  // Two high, two low per instruction cycle
  always_comb
  begin
    st_nxt = st_r;
    // Parked on the last phase: low while held, full high half on restart
    if (hold)
      st_nxt.ph = 2'b11;
    else
      st_nxt.ph = st_r.ph + 2'b01;
    st_nxt.q = ~st_nxt.ph[1];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '{ph: 2'b11, q: 1'b0};
    else if (ce)
      st_r <= st_nxt;
  end

  assign div_clk = st_r.q;

endmodule : ctr_divided_clock_out_div
`default_nettype wire

// File: rtl/ctr_top.sv
// Clock trim and reset control with APB register access
`timescale 1ns/1ps
`default_nettype none
module ctr_top (
  input wire logic pclk,            // System clock, 40 MHz
  input wire logic presetn,         // Power-on reset, async low
  input wire logic ce,              // Clock enable, freezes state
  input wire logic psel,            // APB select
  input wire logic penable,         // APB enable
  input wire logic pwrite,          // APB direction
  input wire logic [11:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready
  output logic pslverr,             // APB error
  input wire logic [2:0] osc_select, // Oscillator mode strap
  input wire logic master_clear_pin_enable,     // Master clear pin function enable
  input wire logic master_clear_pin_n, // Raw master clear pin
  output logic master_clear_pin_out, // Pin drive value
  output logic master_clear_pin_oe_n, // Pin drive enable, low drives
  input wire logic wdt_timeout,     // Watchdog expiry, same clock
  input wire logic int_wake,        // Interrupt wake request
  output logic [3:0] fine_trim,     // Fine trim to oscillator
  output logic coarse_up,           // Large step up
  output logic coarse_down,         // Large step down
  output logic internal_rc_mode_active,        // Internal 4 MHz RC selected
  output logic osc2_clk_en,         // Second osc pin carries clock
  output logic divided_clock_out,   // Oscillator over four
  output logic core_reset,          // Reset to defined-value registers
  output logic wake_pulse,          // Resume from sleep, one cycle
  output logic pc_load,             // Load program counter, one cycle
  output logic [10:0] pc_target,    // Program counter value to load
  output logic [2:0] reset_cause    // Last cause code
);

  // ---------------------------------------------------------------
  // Operation
  // ---------------------------------------------------------------
  // Cause, what it reloads, and the flags it leaves (timeout, powerdown):
  //   power-on       everything, trim to default, flags 1,1
  //   pin, awake     defined-value registers, flags untouched
  //   pin, asleep    defined-value registers, flags 1,0
  //   watchdog       defined-value registers, flags 0,1
  //   watchdog wake  nothing reloaded, flags 0,0, program counter loaded with 000
  //   interrupt wake nothing reloaded, flags 1,0, vector if enabled
  // Trim is a kept register: only power-on resets it, so a calibrated
  // clock survives pin and watchdog resets.
  // Coincident events: only one acts, pin before watchdog before interrupt wake;
  // each overrides only the fields it sets; a same-cycle software write to other fields still lands.
  // Pin reset fires once per low episode, on the filtered rising request,
  // so a pin held low does not restart the core every cycle.
  // The strap is read once after power-on; later changes are ignored
  // until the next power-on, which keeps the clock mode stable.
  // Accesses made while the clock enable is low are lost, although
  // ready still answers high; the bus master must avoid them.
  // The pin is never driven: its enable stays high in every state.
  // Divided clock output stays low outside the two clock-out modes.
  // Program counter loads: reset vector for pin and watchdog resets, interrupt vector
  // only for an interrupt wake with the global enable set.

  typedef struct packed {
    logic [7:0] trim;
    logic sleeping;
    logic global_int_enable;
    logic [2:0] osc;
    logic osc_valid;
    logic to_flag;
    logic pd_flag;
    ctr_pkg::ctr_cause_t cause;
    logic crst;
    logic wake;
    logic pcl;
    logic [10:0] pct;
    logic [31:0] rdata;
    logic master_clear_pin_prev;
  } ctr_state_t;

  ctr_state_t st_r;
  ctr_state_t st_nxt;
  logic master_clear_pin_req;
  logic acc;
  logic wr;
  logic master_clear_pin_rise;
  logic map_hit;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Shared by write strobe and error answer
  function automatic logic ctr_hit(input logic [11:0] a);
    ctr_hit = (a == ctr_pkg::CTR_ADDR_TRIM) || (a == ctr_pkg::CTR_ADDR_CTRL) ||
              (a == ctr_pkg::CTR_ADDR_STATUS) || (a == ctr_pkg::CTR_ADDR_VECTOR);
  endfunction : ctr_hit

  // Oscillator mode with clock out on the second pin
  function automatic logic ctr_divided_clock_out_mode(input logic [2:0] s);
    ctr_divided_clock_out_mode = (s == ctr_pkg::CTR_OSC_IRC_CLK) || (s == ctr_pkg::CTR_OSC_ERC_CLK);
  endfunction : ctr_divided_clock_out_mode

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  ctr_master_clear_pin_filter #(
    .FILT_CYC(ctr_pkg::CTR_MASTER_CLEAR_PIN_FILT_CYC)
  ) u_filt (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .pin_n(master_clear_pin_n),
    .clear_req(master_clear_pin_req)
  );

  // Divider held while the pin is I/O, saves toggling
  ctr_divided_clock_out_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .hold(~ctr_divided_clock_out_mode(st_r.osc)),
    .div_clk(divided_clock_out)
  );

  // ---------------------------------------------------------------
  // Bus strobes
  // ---------------------------------------------------------------
  assign map_hit = ctr_hit(paddr);
  assign acc = psel && penable && ce;
  assign wr = acc && pwrite && map_hit;
  // Disabled pin never resets the core
  assign master_clear_pin_rise = master_clear_pin_req && master_clear_pin_enable && !st_r.master_clear_pin_prev;

  // ---------------------------------------------------------------
  // Readable words
  // ---------------------------------------------------------------
  // Built once so the read mux stays a plain select
  assign ctrl_word = {25'h0000000, st_r.osc, 2'b00, st_r.global_int_enable, st_r.sleeping};
  // Cause and flags side by side
  assign status_word = {25'h0000000, st_r.cause, 2'b00, st_r.pd_flag, st_r.to_flag};

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // Pulses last one cycle
    st_nxt.crst = 1'b0;
    st_nxt.wake = 1'b0;
    st_nxt.pcl = 1'b0;
    // Enabled request level, kept for edge detect
    st_nxt.master_clear_pin_prev = master_clear_pin_req && master_clear_pin_enable;
    // Strap captured after release, not under reset
    if (!st_r.osc_valid)
    begin
      st_nxt.osc = osc_select;
      st_nxt.osc_valid = 1'b1;
    end
    // Factory value arrives by software write
    if (wr && paddr == ctr_pkg::CTR_ADDR_TRIM)
      st_nxt.trim = pwdata[7:0] & ctr_pkg::CTR_TRIM_MASK;
    if (wr && paddr == ctr_pkg::CTR_ADDR_CTRL)
    begin
      st_nxt.sleeping = pwdata[ctr_pkg::CTR_CTRL_SLEEP_BIT];
      st_nxt.global_int_enable = pwdata[ctr_pkg::CTR_CTRL_GIE_BIT];
      // Entering sleep clears powerdown, sets timeout
      if (pwdata[ctr_pkg::CTR_CTRL_SLEEP_BIT] && !st_r.sleeping)
      begin
        st_nxt.pd_flag = 1'b0;
        st_nxt.to_flag = 1'b1;
      end
    end
    if (master_clear_pin_rise)
    begin
      st_nxt.crst = 1'b1;
      st_nxt.pcl = 1'b1;
      st_nxt.pct = ctr_pkg::CTR_RESET_VECTOR;
      st_nxt.global_int_enable = 1'b0;
      st_nxt.sleeping = 1'b0;
      // Sleep gives 1,0; running leaves flags
      if (st_r.sleeping)
      begin
        st_nxt.cause = ctr_pkg::CTR_CAUSE_MASTER_CLEAR_PIN_SLP;
        st_nxt.to_flag = 1'b1;
        st_nxt.pd_flag = 1'b0;
      end
      else
        st_nxt.cause = ctr_pkg::CTR_CAUSE_MASTER_CLEAR_PIN_RUN;
    end
    else if (wdt_timeout && ce)
    begin
      st_nxt.to_flag = 1'b0;
      if (st_r.sleeping)
      begin
        st_nxt.cause = ctr_pkg::CTR_CAUSE_WDT_WAKE;
        st_nxt.pd_flag = 1'b0;
        st_nxt.wake = 1'b1;
        st_nxt.sleeping = 1'b0;
        st_nxt.pcl = 1'b1;
        st_nxt.pct = 11'h000;
      end
      else
      begin
        st_nxt.cause = ctr_pkg::CTR_CAUSE_WDT_RUN;
        st_nxt.pd_flag = 1'b1;
        st_nxt.crst = 1'b1;
        st_nxt.pcl = 1'b1;
        st_nxt.pct = ctr_pkg::CTR_RESET_VECTOR;
        st_nxt.global_int_enable = 1'b0;
      end
    end
    else if (int_wake && st_r.sleeping && ce)
    begin
      st_nxt.cause = ctr_pkg::CTR_CAUSE_INT_WAKE;
      st_nxt.to_flag = 1'b1;
      st_nxt.pd_flag = 1'b0;
      st_nxt.wake = 1'b1;
      st_nxt.sleeping = 1'b0;
      st_nxt.pcl = st_r.global_int_enable;
      st_nxt.pct = st_r.global_int_enable ? ctr_pkg::CTR_INT_VECTOR : 11'h000;
    end
    // Read data captured in setup, returned in access
    st_nxt.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ctr_pkg::CTR_ADDR_TRIM:
          st_nxt.rdata = {24'h000000, st_r.trim};
        ctr_pkg::CTR_ADDR_CTRL:
          st_nxt.rdata = ctrl_word;
        ctr_pkg::CTR_ADDR_STATUS:
          st_nxt.rdata = status_word;
        ctr_pkg::CTR_ADDR_VECTOR:
          st_nxt.rdata = {21'h000000, st_r.pct};
        default:
          st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Only this power-on reset touches kept state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '{
        trim: ctr_pkg::CTR_TRIM_RST,
        sleeping: 1'b0,
        global_int_enable: 1'b0,
        osc: 3'b000,
        osc_valid: 1'b0,
        to_flag: 1'b1,
        pd_flag: 1'b1,
        cause: ctr_pkg::CTR_CAUSE_POR,
        crst: 1'b1,
        wake: 1'b0,
        pcl: 1'b0,
        pct: 11'h000,
        rdata: 32'h0000_0000,
        master_clear_pin_prev: 1'b0
      };
    end
    else if (ce)
      st_r <= st_nxt;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Zero wait states; unmapped answers with error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_hit;
  assign prdata = st_r.rdata;
  assign fine_trim = st_r.trim[7:ctr_pkg::CTR_FINE_LSB];
  assign coarse_up = st_r.trim[ctr_pkg::CTR_COARSE_UP_BIT];
  assign coarse_down = st_r.trim[ctr_pkg::CTR_COARSE_DN_BIT];
  assign internal_rc_mode_active = st_r.osc_valid && (st_r.osc[2:1] == 2'b10);
  assign osc2_clk_en = st_r.osc_valid && ctr_divided_clock_out_mode(st_r.osc);
  assign master_clear_pin_out = 1'b0;
  assign master_clear_pin_oe_n = 1'b1;
  assign core_reset = st_r.crst;
  assign wake_pulse = st_r.wake;
  assign pc_load = st_r.pcl;
  assign pc_target = st_r.pct;
  assign reset_cause = st_r.cause;

endmodule : ctr_top
`default_nettype wire

// File: tb/ctr_monitor.sv
// Assertion checker for the clock trim and reset control block
`timescale 1ns/1ps
`default_nettype none
module ctr_monitor (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [2:0] osc_select, // Mode strap
  input wire logic master_clear_pin_oe_n, // Pin enable
  input wire logic wdt_timeout, // Watchdog expiry
  input wire logic [3:0] fine_trim, // Fine trim
  input wire logic coarse_up, // Step up
  input wire logic coarse_down, // Step down
  input wire logic osc2_clk_en, // Clock pin mode
  input wire logic divided_clock_out, // Clock over four
  input wire logic core_reset, // Core reset pulse
  input wire logic wake_pulse, // Wake pulse
  input wire logic pc_load, // PC load
  input wire logic [10:0] pc_target // PC value
);
  // ----------------------------
  // Properties
  // ----------------------------
  // Single domain, so clock and disable are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pin_never_driven_a: assert property (master_clear_pin_oe_n)
    else $error("master clear pin driven");
  clk_en_mode_a: assert property (osc2_clk_en |-> osc_select[2] && osc_select[0])
    else $error("clock pin mode outside 101 or 111");
  divided_clock_out_gated_a: assert property (divided_clock_out |-> osc2_clk_en)
    else $error("divided clock outside clock-out mode");
  // Two high, two low, with no stretch
  divided_clock_out_period_a: assert property ($rose(divided_clock_out) |=> divided_clock_out
    ##1 !divided_clock_out [*2] ##1 divided_clock_out)
    else $error("divided clock period wrong");
  wdt_acts_a: assert property (wdt_timeout |=> core_reset || wake_pulse)
    else $error("watchdog expiry ignored");
  wake_keeps_a: assert property (wake_pulse |-> !core_reset)
    else $error("wake-up reset the core");
  reset_vector_a: assert property (pc_load && !wake_pulse |-> pc_target == 11'h000)
    else $error("reset load not at address zero");
  trim_write_a: assert property (psel && penable && pwrite && paddr == 12'h000
    |=> fine_trim == $past(pwdata[7:4]) && coarse_up == $past(pwdata[3])
    && coarse_down == $past(pwdata[2]))
    else $error("trim outputs not updated");
endmodule : ctr_monitor

bind ctr_top ctr_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .osc_select, .master_clear_pin_oe_n, .wdt_timeout, .fine_trim, .coarse_up, .coarse_down,
  .osc2_clk_en, .divided_clock_out, .core_reset, .wake_pulse, .pc_load, .pc_target);
`default_nettype wire

// File: tb/ctr_top_test.sv
// Self-checking bench for the clock trim and reset control block
`timescale 1ns/1ps
`default_nettype none
module ctr_top_test;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err, cr, wp, pl;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] osc_select, reset_cause;
  logic master_clear_pin_enable, master_clear_pin_n, master_clear_pin_out, master_clear_pin_oe_n;
  logic wdt_timeout, int_wake, coarse_up, coarse_down, internal_rc_mode_active, osc2_clk_en;
  logic divided_clock_out, core_reset, wake_pulse, pc_load;
  logic [3:0] fine_trim;
  logic [10:0] pc_target, pt;
  int failures = 0;
  int total_checks = 0;

  ctr_top DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .osc_select, .master_clear_pin_enable, .master_clear_pin_n, .master_clear_pin_out,
    .master_clear_pin_oe_n, .wdt_timeout, .int_wake, .fine_trim, .coarse_up, .coarse_down,
    .internal_rc_mode_active, .osc2_clk_en, .divided_clock_out, .core_reset, .wake_pulse, .pc_load,
    .pc_target, .reset_cause);

  // 40 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------
  // Shared tasks
  // ----------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // One APB transfer; waits on pready, bounded
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      failures++;
      final_report();
    end
  endtask : apb

  // Collects one-cycle pulses over n cycles
  task watch(input int n);
    cr = 1'b0;
    wp = 1'b0;
    pl = 1'b0;
    repeat (n)
    begin
      #1;
      cr = cr | core_reset;
      wp = wp | wake_pulse;
      if (pc_load === 1'b1)
      begin
        pl = 1'b1;
        pt = pc_target;
      end
      @(posedge pclk);
    end
  endtask : watch

  task rst(input logic [2:0] o);
    presetn <= 1'b0;
    osc_select <= o;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : rst

  // Single-cycle watchdog or interrupt event
  task pulse(input logic w);
    @(posedge pclk);
    if (w)
      wdt_timeout <= 1'b1;
    else
      int_wake <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    int_wake <= 1'b0;
    watch(6);
  endtask : pulse

  task pin_low(input int len);
    @(posedge pclk);
    master_clear_pin_n <= 1'b0;
    watch(len);
    master_clear_pin_n <= 1'b1;
  endtask : pin_low

  // ----------------------------
  // Scenarios
  // ----------------------------
  // Every strap code, with power-on values
  task t_osc;
    int c;
    for (int i = 0; i < 8; i++)
    begin
      rst(i[2:0]);
      c = 0;
      repeat (8)
      begin
        @(posedge pclk);
        #1;
        c += int'(divided_clock_out === 1'b1);
      end
      chk(internal_rc_mode_active, i == 4 || i == 5, "internal_rc_mode");
      chk(osc2_clk_en, i == 5 || i == 7, "clk pin");
      chk(c, (i == 5 || i == 7) ? 4 : 0, "div high");
      apb(1'b0, ctr_pkg::CTR_ADDR_TRIM, 32'h0);
      chk(rd, 32'h70, "trim rst");
      apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
      chk(rd, 32'h3, "por flags");
      apb(1'b0, ctr_pkg::CTR_ADDR_CTRL, 32'h0);
      chk(rd, 32'(i << 4), "ctrl rst");
    end
  endtask : t_osc

  // Fine and coarse fields; low bits never stored
  task t_trim;
    logic [7:0] v[3];
    v = '{8'hFF, 8'h08, 8'h94};
    foreach (v[k])
    begin
      apb(1'b1, ctr_pkg::CTR_ADDR_TRIM, {24'h0, v[k]});
      #1;
      chk(fine_trim, v[k][7:4], "fine");
      chk({coarse_up, coarse_down}, v[k][3:2], "coarse");
      apb(1'b0, ctr_pkg::CTR_ADDR_TRIM, 32'h0);
      chk(rd, v[k] & 8'hFC, "trim read");
    end
    apb(1'b1, 12'h010, 32'hFF);
    chk(err, 1'b1, "unmapped wr");
    apb(1'b0, 12'h010, 32'h0);
    chk(err, 1'b1, "unmapped rd err");
    chk(rd, 32'h0, "unmapped rd");
  endtask : t_trim

  // Watchdog while running, then while asleep
  task t_wdt;
    pulse(1'b1);
    chk({cr, wp}, 2'b10, "wdt run");
    apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
    chk(rd, 32'h32, "wdt flags");
    apb(1'b0, ctr_pkg::CTR_ADDR_TRIM, 32'h0);
    chk(rd, 32'h94, "trim kept");
    chk(master_clear_pin_oe_n, 1'b1, "pin oe");
    chk(master_clear_pin_out, 1'b0, "pin out");
    chk(reset_cause, ctr_pkg::CTR_CAUSE_WDT_RUN, "wdt cause");
    apb(1'b1, ctr_pkg::CTR_ADDR_CTRL, 32'h1);
    apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'b01, "sleep flags");
    pulse(1'b1);
    chk({cr, wp}, 2'b01, "wdt wake");
    apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
    chk(rd, 32'h40, "wake flags");
  endtask : t_wdt

  // Interrupt wake without and with the global enable
  task t_int;
    for (int g = 0; g < 2; g++)
    begin
      apb(1'b1, ctr_pkg::CTR_ADDR_CTRL, 32'(2 * g + 1));
      pulse(1'b0);
      chk({cr, wp, pl}, {2'b01, g[0]}, "int wake");
      if (g == 1)
        chk(pt, ctr_pkg::CTR_INT_VECTOR, "vector");
      apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
      chk(rd, 32'h51, "int flags");
    end
    pulse(1'b0);
    chk(wp, 1'b0, "int awake");
  endtask : t_int

  // Pin glitch, pin reset awake and asleep, pin disabled
  task t_pin;
    pin_low(4);
    chk(cr, 1'b0, "glitch");
    watch(16);
    chk(cr, 1'b0, "glitch late");
    pin_low(20);
    chk(cr, 1'b1, "pin run");
    apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
    chk(rd, 32'h11, "pin run flags");
    apb(1'b1, ctr_pkg::CTR_ADDR_CTRL, 32'h1);
    pin_low(20);
    apb(1'b0, ctr_pkg::CTR_ADDR_STATUS, 32'h0);
    chk(rd, 32'h21, "pin sleep flags");
    master_clear_pin_enable <= 1'b0;
    pin_low(20);
    chk(cr, 1'b0, "pin off");
    master_clear_pin_enable <= 1'b1;
  endtask : t_pin

  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    osc_select = 3'h0;
    master_clear_pin_enable = 1'b1;
    master_clear_pin_n = 1'b1;
    wdt_timeout = 1'b0;
    int_wake = 1'b0;
    t_osc();
    t_trim();
    t_wdt();
    t_int();
    t_pin();
    final_report();
  end
endmodule : ctr_top_test
`default_nettype wire
